// *** dv/transceiver_reset_control_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module transceiver_reset_control_tb;
  localparam int SWC = 20;
  localparam int PUC = 50;
  logic core_clk = 1'b0;
  logic rst_b, v16, v250, vmar, vfast, cmd_valid, cmd_ready, hw_req;
  logic reset_active, gdd, sw_seen, device_ready;
  logic [15:0] cmd_data;
  int err_count, comparisons, pulses;
  wire logic [2:0] mon = {cmd_ready, device_ready, reset_active};

  trc_link_if i_trc_link_if ();
  trc_device #(.SW_RST_CYC(SWC)) i_trc_device (
    .core_clk(core_clk), .rst_b(rst_b), .link(i_trc_link_if),
    .vdd_above_1v6(v16), .vdd_above_250mv(v250), .vdd_ramp_margin(vmar), .vdd_fast_rise(vfast),
    .reset_active(reset_active), .glitch_detect_disable(gdd), .sw_reset_seen(sw_seen));
  trc_host #(.POWERUP_CYC(PUC), .SETTLE_CYC(20)) i_trc_host (
    .core_clk(core_clk), .rst_b(rst_b), .link(i_trc_link_if), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .hw_reset_req(hw_req), .device_ready(device_ready));
  trc_link_assertions #(.SETTLE(20)) i_trc_link_assertions (
    .core_clk(core_clk), .rst_b(rst_b), .sck(i_trc_link_if.sck), .sel_n(i_trc_link_if.sel_n),
    .dev_rst_o(i_trc_link_if.dev_rst_o), .dev_rst_oe_n(i_trc_link_if.dev_rst_oe_n),
    .host_rst_o(i_trc_link_if.host_rst_o), .host_rst_oe_n(i_trc_link_if.host_rst_oe_n),
    .rst_pin_n(i_trc_link_if.rst_pin_n));

  always #12.5 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    if (sw_seen === 1'b1) begin
      pulses++;
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wait_on(input int sel, input logic lvl, output int n);
    n = 0;
    while (mon[sel] !== lvl) begin
      @(negedge core_clk);
      n++;
      if (n > 3000) begin
        err_count++;
        $display("BAD wait_%0d exp %b seen %b", sel, lvl, mon[sel]);
        stop_test();
      end
    end
  endtask
  task automatic send(input logic [15:0] w);
    int n;
    wait_on(2, 1'b1, n);
    cmd_data = w;
    cmd_valid = 1'b1;
    cyc(1);
    cmd_valid = 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic power_up();
    int n;
    cyc(10);
    chk("low_vdd", reset_active, 1'b1);
    v16 = 1'b1;
    v250 = 1'b1;
    cyc(10);
    chk("no_margin", reset_active, 1'b1);
    chk("pin_held", i_trc_link_if.rst_pin_n, 1'b0);
    vmar = 1'b1;
    wait_on(1, 1'b1, n);
    chk("up_wait", n >= PUC && n <= PUC + 12, 1'b1);
    chk("rst_end", reset_active, 1'b0);
    chk("gdd_def", gdd, 1'b0);
    chk("pin_free", i_trc_link_if.rst_pin_n, 1'b1);
  endtask
  task automatic glitch_sens();
    int n;
    vfast = 1'b1;
    wait_on(0, 1'b1, n);
    chk("glitch_lat", n <= 8, 1'b1);
    chk("glitch_pin", i_trc_link_if.rst_pin_n, 1'b0);
    vfast = 1'b0;
    cyc(40);
    wait_on(1, 1'b1, n);
  endtask
  task automatic sw_reset();
    int p, n, len;
    p = pulses;
    send(16'hfe00);
    wait_on(0, 1'b1, n);
    wait_on(0, 1'b0, len);
    chk("sw_pulse", 16'(pulses), 16'(p + 1));
    chk("sw_len", len >= SWC - 2 && len <= SWC + 10, 1'b1);
    cyc(40);
    wait_on(1, 1'b1, n);
  endtask
  task automatic normal_mode();
    int p, n;
    send(16'hca01);
    cyc(150);
    chk("gdd_set", gdd, 1'b1);
    vfast = 1'b1;
    cyc(10);
    chk("no_glitch", reset_active, 1'b0);
    vfast = 1'b0;
    v16 = 1'b0;
    cyc(10);
    chk("dip_1v6", reset_active, 1'b0);
    p = pulses;
    send(16'hfe00);
    cyc(150);
    chk("sw_ignored", 16'(pulses), 16'(p));
    chk("sw_no_rst", reset_active, 1'b0);
    v250 = 1'b0;
    cyc(10);
    chk("dip_250", reset_active, 1'b1);
    v16 = 1'b1;
    v250 = 1'b1;
    cyc(40);
    wait_on(1, 1'b1, n);
    chk("gdd_back", gdd, 1'b0);
  endtask
  task automatic pin_reset();
    int n;
    send(16'hca01);
    cyc(150);
    chk("gdd_pre", gdd, 1'b1);
    hw_req = 1'b1;
    cyc(1);
    hw_req = 1'b0;
    wait_on(0, 1'b1, n);
    chk("pin_low", i_trc_link_if.rst_pin_n, 1'b0);
    cyc(40);
    wait_on(1, 1'b1, n);
    chk("gdd_pin", gdd, 1'b0);
  endtask

  initial begin
    {rst_b, v16, v250, vmar, vfast, cmd_valid, hw_req} = 7'h00;
    cmd_data = 16'h0000;
    cyc(5);
    rst_b = 1'b1;
    power_up();
    glitch_sens();
    sw_reset();
    normal_mode();
    pin_reset();
    stop_test();
  end
endmodule
`default_nettype wire

// *** dv/trc_link_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module trc_link_assertions #(
  parameter int SETTLE = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Link
  input wire logic sck,
  input wire logic sel_n,
  input wire logic dev_rst_o,
  input wire logic dev_rst_oe_n,
  input wire logic host_rst_o,
  input wire logic host_rst_oe_n,
  input wire logic rst_pin_n
);
  int   hi_cnt;
  int   rise_cnt;
  logic sck_q;
  // ----------------------------------------
  // Cycles since pin high, sck rises per frame
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_cnt <= 0;
      rise_cnt <= 0;
      sck_q <= 1'b0;
    end else begin
      hi_cnt <= !rst_pin_n ? 0 : (hi_cnt < 1000 ? hi_cnt + 1 : hi_cnt);
      rise_cnt <= sel_n ? 0 : rise_cnt + int'(sck && !sck_q);
      sck_q <= sck;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence host_pull_s;
    !host_rst_oe_n [*8] ##1 host_rst_oe_n;
  endsequence
  sequence dev_join_s;
    dev_rst_oe_n [*8];
  endsequence
  pin_level_a: assert property (rst_pin_n == !((!dev_rst_oe_n && !dev_rst_o) || (!host_rst_oe_n && !host_rst_o)))
    else $error("pin level wrong");
  dev_od_a: assert property (!dev_rst_o) else $error("device drives pin high");
  host_od_a: assert property (!host_rst_o) else $error("host drives pin high");
  host_pulse_a: assert property ($fell(host_rst_oe_n) |-> host_pull_s) else $error("host pull length");
  dev_join_a: assert property ($fell(host_rst_oe_n) && dev_rst_oe_n |-> dev_join_s) else $error("device latches host pull");
  dev_hold_a: assert property ($fell(dev_rst_oe_n) |-> !dev_rst_oe_n [*8]) else $error("device pull short");
  sck_idle_a: assert property (sel_n |-> !sck) else $error("sck not idle");
  frame_gate_a: assert property ($fell(sel_n) |-> rst_pin_n) else $error("frame during reset");
  settle_wait_a: assert property ($fell(sel_n) |-> hi_cnt >= SETTLE) else $error("frame too early");
  frame_len_a: assert property ($rose(sel_n) |-> rise_cnt == 16) else $error("frame not 16 bits");
endmodule
`default_nettype wire

// *** verilog/trc_device.sv ***
`timescale 1ns/100ps
`default_nettype none
module trc_device #(
  parameter int SW_RST_CYC = trc_pkg::SW_RST_CYC
) (
  // Clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst_b,
  // Link to host
  trc_link_if.dev     link,
  // Supply comparators
  input  wire logic   vdd_above_1v6,
  input  wire logic   vdd_above_250mv,
  input  wire logic   vdd_ramp_margin,
  input  wire logic   vdd_fast_rise,
  // Status
  output logic        reset_active,
  output logic        glitch_detect_disable,
  output logic        sw_reset_seen
);
  localparam int TMR_W = $clog2(SW_RST_CYC + 1);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [7:0] sync_q;
  wire        sck_s    = sync_q[7];
  wire        sel_n_s  = sync_q[6];
  wire        sdi_s    = sync_q[5];
  wire        pin_n_s  = sync_q[4];
  wire        v1v6_s   = sync_q[3];
  wire        v250_s   = sync_q[2];
  wire        margin_s = sync_q[1];
  wire        fast_s   = sync_q[0];

  trc_sync #(
    .W       (8),
    .RST_VAL (8'h50)
  ) u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .d_in     ({link.sck, link.sel_n, link.sdi, link.rst_pin_n,
                vdd_above_1v6, vdd_above_250mv, vdd_ramp_margin, vdd_fast_rise}),
    .d_out    (sync_q)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic             powered_reg;
  logic [TMR_W-1:0] tmr_reg;
  logic [7:0]       cfg_reg;
  logic             sck_d_reg;
  logic             sel_d_reg;
  logic [15:0]      shift_reg;
  logic [4:0]       bits_reg;
  logic             oe_n_reg;
  logic             drv_reg;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire sensitive    = !cfg_reg[trc_pkg::GDD_BIT];
  wire supply_ok    = v1v6_s && margin_s;
  wire supply_lost  = sensitive ? !v1v6_s : !v250_s;
  wire tmr_busy     = (tmr_reg != '0);
  wire internal_rst = !powered_reg || tmr_busy;
  wire in_reset     = internal_rst || !pin_n_s;
  wire sck_rise     = sck_s && !sck_d_reg;
  wire sel_rise     = sel_n_s && !sel_d_reg;
  wire cmd_done     = sel_rise && (bits_reg == 5'd16) && !in_reset;
  wire sw_hit       = cmd_done && (shift_reg == trc_pkg::CMD_SW_RESET) && sensitive;
  wire cfg_hit      = cmd_done && (shift_reg[15:8] == trc_pkg::CMD_CFG_CODE);
  wire glitch_hit   = powered_reg && sensitive && fast_s && margin_s;

  // ----------------------------------------
  // Supply tracking
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      powered_reg <= 1'b0;
    end else if (!powered_reg) begin
      powered_reg <= supply_ok;
    end else if (supply_lost) begin
      powered_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Short reset timer
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tmr_reg <= '0;
    end else if (sw_hit || glitch_hit) begin
      tmr_reg <= TMR_W'(SW_RST_CYC);
    end else if (tmr_busy) begin
      tmr_reg <= tmr_reg - 1'b1;
    end
  end

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_reg <= trc_pkg::CFG_RESET;
    end else if (in_reset) begin
      cfg_reg <= trc_pkg::CFG_RESET;
    end else if (cfg_hit) begin
      cfg_reg <= shift_reg[7:0];
    end
  end

  // ----------------------------------------
  // Serial receiver
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_d_reg <= 1'b0;
      sel_d_reg <= 1'b1;
      shift_reg <= '0;
      bits_reg  <= '0;
    end else begin
      sck_d_reg <= sck_s;
      sel_d_reg <= sel_n_s;
      if (in_reset || sel_n_s) begin
        bits_reg <= '0;
      end else if (sck_rise) begin
        shift_reg <= {shift_reg[14:0], sdi_s};
        if (bits_reg != 5'd31) begin
          bits_reg <= bits_reg + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Reset pin and status
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      oe_n_reg              <= 1'b0;
      drv_reg               <= 1'b0;
      reset_active          <= 1'b1;
      glitch_detect_disable <= 1'b0;
      sw_reset_seen         <= 1'b0;
    end else begin
      oe_n_reg              <= !internal_rst;
      drv_reg               <= 1'b0;
      reset_active          <= in_reset;
      glitch_detect_disable <= cfg_reg[trc_pkg::GDD_BIT];
      sw_reset_seen         <= sw_hit;
    end
  end

  assign link.dev_rst_o    = drv_reg;
  assign link.dev_rst_oe_n = oe_n_reg;
endmodule
`default_nettype wire

// *** verilog/trc_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module trc_host #(
  parameter int POWERUP_CYC = trc_pkg::POWERUP_WAIT_CYC,
  parameter int SETTLE_CYC  = trc_pkg::PIN_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Link to device
  trc_link_if.host         link,
  // Command port
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_data,
  output logic             cmd_ready,
  // Hardware reset request
  input  wire logic        hw_reset_req,
  // Status
  output logic             device_ready
);
  typedef enum logic [2:0] {H_BOOT, H_IDLE, H_PINRST, H_SETTLE, H_SHIFT, H_END} trc_hstate_e;

  // ----------------------------------------
  // State
  // ----------------------------------------
  trc_hstate_e  st_reg;
  logic [31:0]  tmr_reg;
  logic [15:0]  sh_reg;
  logic [3:0]   bit_reg;
  logic         sck_reg;
  logic         sel_n_reg;
  logic         sdi_reg;
  logic         oe_n_reg;
  logic         swrst_reg;
  logic         pin_n_s;

  trc_sync #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .d_in     (link.rst_pin_n),
    .d_out    (pin_n_s)
  );

  wire        tmr_zero = (tmr_reg == 32'h0);
  wire [31:0] half_ld  = 32'(trc_pkg::SCK_HALF_CYC - 1);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg       <= H_BOOT;
      tmr_reg      <= 32'h0;
      sh_reg       <= 16'h0000;
      bit_reg      <= 4'h0;
      sck_reg      <= 1'b0;
      sel_n_reg    <= 1'b1;
      sdi_reg      <= 1'b0;
      oe_n_reg     <= 1'b1;
      swrst_reg    <= 1'b0;
      cmd_ready    <= 1'b0;
      device_ready <= 1'b0;
    end else begin
      if (!tmr_zero) begin
        tmr_reg <= tmr_reg - 32'h1;
      end
      case (st_reg)
        H_BOOT: begin
          if (tmr_zero && pin_n_s) begin
            tmr_reg <= 32'(POWERUP_CYC - 1);
            st_reg  <= H_SETTLE;
          end
        end
        H_IDLE: begin
          if (hw_reset_req) begin
            cmd_ready    <= 1'b0;
            device_ready <= 1'b0;
            oe_n_reg     <= 1'b0;
            tmr_reg      <= 32'(trc_pkg::HOST_RST_LOW_CYC - 1);
            st_reg       <= H_PINRST;
          end else if (!pin_n_s) begin
            // Device-side reset seen on the pin: hold commands until it settles
            cmd_ready    <= 1'b0;
            device_ready <= 1'b0;
            tmr_reg      <= 32'(SETTLE_CYC - 1);
            st_reg       <= H_SETTLE;
          end else if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            swrst_reg <= (cmd_data == trc_pkg::CMD_SW_RESET);
            sh_reg    <= cmd_data;
            sdi_reg   <= cmd_data[15];
            sel_n_reg <= 1'b0;
            bit_reg   <= 4'h0;
            tmr_reg   <= half_ld;
            st_reg    <= H_SHIFT;
          end
        end
        H_PINRST: begin
          if (tmr_zero) begin
            oe_n_reg <= 1'b1;
            tmr_reg  <= 32'(SETTLE_CYC - 1);
            st_reg   <= H_SETTLE;
          end
        end
        H_SETTLE: begin
          if (!pin_n_s) begin
            tmr_reg <= 32'(SETTLE_CYC - 1);
          end else if (tmr_zero) begin
            cmd_ready    <= 1'b1;
            device_ready <= 1'b1;
            st_reg       <= H_IDLE;
          end
        end
        H_SHIFT: begin
          if (tmr_zero) begin
            tmr_reg <= half_ld;
            sck_reg <= !sck_reg;
            if (sck_reg) begin
              sh_reg  <= {sh_reg[14:0], 1'b0};
              sdi_reg <= sh_reg[14];
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == 4'hf) begin
                st_reg <= H_END;
              end
            end
          end
        end
        H_END: begin
          if (tmr_zero) begin
            sel_n_reg <= 1'b1;
            if (swrst_reg) begin
              device_ready <= 1'b0;
              tmr_reg      <= 32'(SETTLE_CYC - 1);
              st_reg       <= H_SETTLE;
            end else begin
              cmd_ready <= 1'b1;
              st_reg    <= H_IDLE;
            end
          end
        end
        default: begin
          st_reg <= H_BOOT;
        end
      endcase
    end
  end

  assign link.sck           = sck_reg;
  assign link.sel_n         = sel_n_reg;
  assign link.sdi           = sdi_reg;
  assign link.host_rst_o    = 1'b0;
  assign link.host_rst_oe_n = oe_n_reg;
endmodule
`default_nettype wire

// *** verilog/trc_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface trc_link_if;
  logic sck;
  logic sel_n;
  logic sdi;
  logic dev_rst_o;
  logic dev_rst_oe_n;
  logic host_rst_o;
  logic host_rst_oe_n;
  logic rst_pin_n;

  // Open-drain wire with weak pull-up
  assign rst_pin_n = !((!dev_rst_oe_n && !dev_rst_o) || (!host_rst_oe_n && !host_rst_o));

  modport dev  (input sck, sel_n, sdi, rst_pin_n, output dev_rst_o, dev_rst_oe_n);
  modport host (input rst_pin_n, output sck, sel_n, sdi, host_rst_o, host_rst_oe_n);
endinterface
`default_nettype wire

// *** verilog/trc_pkg.sv ***
// What this block does
// - Power-up restores every control register value
// - Serial commands ignored while any reset active
// - Host waits 100 ms after first pin release; a pin low in that wait cuts it to 0.25 ms
// - Hold reset below 1.6V or ramp margin
// - Sensitive mode: fast rise plus margin resets
// - Sensitive default; config bit 0 disables detection
// - Falling supply resets only at mode level
// - Any reset re-enables sensitive mode
// - Command 0xfe00 resets only in sensitive mode
// - Software reset restores registers, lasts 0.25 ms
// - Host pulling reset pin low resets device
// - Host waits 0.25 ms after pin reset
// - Reset pin is open-drain, active low, readable
`default_nettype none
package trc_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS    = 25;
  localparam int POWERUP_WAIT_MS  = 100;
  localparam int POWERUP_WAIT_CYC = POWERUP_WAIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SW_RST_US        = 250;
  localparam int SW_RST_CYC       = SW_RST_US * 1000 / CLK_PERIOD_NS;
  localparam int PIN_SETTLE_US    = 250;
  localparam int PIN_SETTLE_CYC   = PIN_SETTLE_US * 1000 / CLK_PERIOD_NS;
  localparam int HOST_RST_LOW_CYC = 8;
  localparam int SCK_HALF_CYC     = 4;
  // ----------------------------------------
  // Serial command layout
  // ----------------------------------------
  localparam int          CMD_W        = 16;
  localparam logic [15:0] CMD_SW_RESET = 16'hfe00;
  localparam logic [7:0]  CMD_CFG_CODE = 8'hca;
  // ----------------------------------------
  // fifo_reset_config_register
  // ----------------------------------------
  localparam logic [7:0]  CFG_RESET    = 8'h00;
  localparam int          GDD_BIT      = 0;
endpackage
`default_nettype wire

// *** verilog/trc_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module trc_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= RST_VAL;
      d_out    <= RST_VAL;
    end else begin
      meta_reg <= d_in;
      d_out    <= meta_reg;
    end
  end
endmodule
`default_nettype wire
